// ---- verilog/rep_reset_event_pins.sv ----
// Contract
// - hard reset returns all logic to reset
// - port reset request asserts link reset output
// - no self-reset: hold until software clears
// - self-reset: hold until self-reset finishes
// - hard reset leaves link reset output inactive
// - input event pin edge sends symbol everywhere
// - output event pin toggles once per cycle with any enabled symbol
// - active-low open-drain interrupt output
// - event window counted in clk_sys cycles, scaled from nominal bus clock rate; this block never uses MCE_HOLD_CYC, the output pin toggles on every hit cycle
`timescale 1ns/1ps
`default_nettype none

module rep_reset_event_pins #(
  parameter int NUM_PORTS = rep_pkg::NUM_PORTS_DEF
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic link_rst_req,
  input wire logic self_rst_sel,
  input wire logic self_rst_done,
  input wire logic rst_req_clear,
  output var logic link_reset_out_n_o,
  output var logic link_reset_out_n_oe,
  input wire logic mce_dir_out,
  input wire logic multicast_event_pin_i,
  output var logic multicast_event_pin_o,
  output var logic multicast_event_pin_oe,
  input wire logic [NUM_PORTS-1:0] mce_rx,
  input wire logic [NUM_PORTS-1:0] mce_port_en,
  output var logic [NUM_PORTS-1:0] mce_tx_req,
  input wire logic irq_pending,
  output var logic int_out_n_o,
  output var logic int_out_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  if (NUM_PORTS < 1 || NUM_PORTS > rep_pkg::NUM_PORTS_MAX) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // link reset output sequencer
  rep_pkg::rep_lrst_e state;
  rep_pkg::rep_lrst_e next_state;

  // next state; a new request wins over any release
  always_comb begin
    next_state = state;
    unique case (state)
      rep_pkg::REP_LRST_IDLE: begin
        if (link_rst_req) begin
          next_state = self_rst_sel ? rep_pkg::REP_LRST_HOLD_SELF
                                    : rep_pkg::REP_LRST_HOLD_SW;
        end
      end
      rep_pkg::REP_LRST_HOLD_SW: begin
        if (rst_req_clear && !link_rst_req) begin
          next_state = rep_pkg::REP_LRST_IDLE;
        end
      end
      rep_pkg::REP_LRST_HOLD_SELF: begin
        if (self_rst_done && !link_rst_req) begin
          next_state = rep_pkg::REP_LRST_IDLE;
        end
      end
      default: begin
        next_state = rep_pkg::REP_LRST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= rep_pkg::REP_LRST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // open-drain drive, registered from the next state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_reset_out_n_oe <= rep_pkg::OD_OE_RST;
      link_reset_out_n_o <= rep_pkg::OD_LOW;
    end else begin
      link_reset_out_n_oe <= (next_state != rep_pkg::REP_LRST_IDLE);
      link_reset_out_n_o <= rep_pkg::OD_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event pin, input direction
  logic mce_level;
  logic mce_change;

  // pin crosses three flops before edge detection
  rep_pin_sync #(
    .STAGES(rep_pkg::SYNC_STAGES)
  ) u_mce_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(multicast_event_pin_i),
    .level(mce_level),
    .change(mce_change)
  );

  // one-cycle send request to every port per edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mce_tx_req <= '0;
    end else if (!mce_dir_out && mce_change) begin
      mce_tx_req <= '1;
    end else begin
      mce_tx_req <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event pin, output direction
  logic mce_rx_hit;

  // any enabled port saw an event symbol
  assign mce_rx_hit = |(mce_rx & mce_port_en);

  // toggle level; enable follows direction
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      multicast_event_pin_o <= rep_pkg::MCE_LEVEL_RST;
      multicast_event_pin_oe <= rep_pkg::OD_OE_RST;
    end else begin
      multicast_event_pin_oe <= mce_dir_out;
      if (mce_dir_out && mce_rx_hit) begin
        multicast_event_pin_o <= !multicast_event_pin_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output, pulled low while pending
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_out_n_oe <= rep_pkg::OD_OE_RST;
      int_out_n_o <= rep_pkg::OD_LOW;
    end else begin
      int_out_n_oe <= irq_pending;
      int_out_n_o <= rep_pkg::OD_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // broadcast send request: one cycle all ports, then quiet
  sequence s_tx_pulse;
    (mce_tx_req == {NUM_PORTS{1'b1}}) ##1 (mce_tx_req == '0);
  endsequence

  // link reset held low for two cycles
  sequence s_lrst_held;
    link_reset_out_n_oe [*2];
  endsequence

  a_req_drives_rst:
    assert property (link_rst_req |=> link_reset_out_n_oe && !link_reset_out_n_o)
    else $error("link reset not driven after request");

  a_sw_hold_rst:
    assert property (((state == rep_pkg::REP_LRST_HOLD_SW) && !rst_req_clear)
                     ##1 !rst_req_clear |-> s_lrst_held)
    else $error("link reset dropped without software clear");

  a_sw_release_rst:
    assert property ((state == rep_pkg::REP_LRST_HOLD_SW) && rst_req_clear
                     && !link_rst_req |=> !link_reset_out_n_oe)
    else $error("link reset not released on clear");

  a_self_release_rst:
    assert property ((state == rep_pkg::REP_LRST_HOLD_SELF) && self_rst_done
                     && !link_rst_req |=> !link_reset_out_n_oe)
    else $error("link reset not released after self-reset");

  a_self_ignore_clear:
    assert property ((state == rep_pkg::REP_LRST_HOLD_SELF) && rst_req_clear
                     && !self_rst_done |=> link_reset_out_n_oe)
    else $error("self-reset hold released by software clear");

  a_hard_rst_quiet:
    assert property (@(posedge clk_sys) disable iff (1'b0)
                     srst ##1 !srst |-> !link_reset_out_n_oe && !int_out_n_oe
                     && (mce_tx_req == '0) && !multicast_event_pin_oe)
    else $error("outputs not quiet after hard reset");

  a_edge_sends_all:
    assert property (!mce_dir_out && mce_change |=> s_tx_pulse)
    else $error("input edge did not send to all ports");

  a_settled_edge:
    assert property (!mce_dir_out && $rose(u_mce_sync.level) |-> ##[0:1] mce_change)
    else $error("settled level change not detected");

  a_out_toggle:
    assert property (mce_dir_out && mce_rx_hit
                     |=> multicast_event_pin_o != $past(multicast_event_pin_o))
    else $error("event pin did not toggle");

  a_out_steady:
    assert property (!mce_rx_hit |=> $stable(multicast_event_pin_o))
    else $error("event pin toggled without symbol");

  a_int_follows:
    assert property (irq_pending ##1 irq_pending |-> ##0 int_out_n_oe ##1 1'b1)
    else $error("interrupt output not driven while pending");

endmodule

`default_nettype wire

// ---- inc/rep_pkg.sv ----
package rep_pkg;

  // system clock rate of this block
  localparam longint CLK_SYS_HZ = 40_000_000;
  // nominal register-bus clock that times the event pin window
  localparam longint REGBUS_NOM_HZ = 100_000_000;
  // event pin hold window, in register-bus cycles
  localparam int MCE_HOLD_REGBUS_CYC = 10;
  // same window in clk_sys cycles, rounded up, at least one
  localparam int MCE_HOLD_CYC_RAW = int'((MCE_HOLD_REGBUS_CYC * CLK_SYS_HZ
                                          + REGBUS_NOM_HZ - 1) / REGBUS_NOM_HZ);
  localparam int MCE_HOLD_CYC = (MCE_HOLD_CYC_RAW < 1) ? 1 : MCE_HOLD_CYC_RAW;

  // pin synchroniser depth
  localparam int SYNC_STAGES = 3;
  // default number of serial ports
  localparam int NUM_PORTS_DEF = 16;
  localparam int NUM_PORTS_MAX = 32;

  // reset values of pin-facing flops
  localparam logic OD_OE_RST = 1'b0;
  localparam logic OD_LOW = 1'b0;
  localparam logic MCE_LEVEL_RST = 1'b0;

  // link reset output sequencer, one-hot
  typedef enum logic [2:0] {
    REP_LRST_IDLE = 3'h1,
    REP_LRST_HOLD_SW = 3'h2,
    REP_LRST_HOLD_SELF = 3'h4
  } rep_lrst_e;

endpackage

// ---- verilog/rep_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module rep_pin_sync #(
  parameter int STAGES = rep_pkg::SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic pin_in,
  output var logic level,
  output var logic change
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  if (STAGES < rep_pkg::SYNC_STAGES) begin : g_bad_stages
    $error("rep_pin_sync needs at least three stages");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [STAGES-1:0] sync_sr;
  logic primed;
  logic agree;

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_sr <= '0;
    end else begin
      sync_sr <= {sync_sr[STAGES-2:0], pin_in};
    end
  end

  // last two stages must agree before a level counts
  assign agree = (sync_sr[STAGES-1] == sync_sr[STAGES-2]);

  // settled level and one-cycle change pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level <= rep_pkg::MCE_LEVEL_RST;
      primed <= 1'b0;
      change <= 1'b0;
    end else begin
      change <= 1'b0;
      if (agree) begin
        primed <= 1'b1; // first agreement only loads, no edge
        level <= sync_sr[STAGES-2];
        change <= primed && (sync_sr[STAGES-2] != level);
      end
    end
  end

endmodule

`default_nettype wire

// ---- verification/rep_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module rep_board_model (
  input wire logic clk_sys,
  input wire logic ev_drive,
  input wire logic ev_level,
  input wire logic lrst_o,
  input wire logic lrst_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic mce_o,
  input wire logic mce_oe,
  output var logic lrst_pin,
  output var logic int_pin,
  output var logic mce_pin
);
  logic held = 1'b0;
  logic [3:0] stable_cnt = 4'h0;

  ////////////////////////////////////////////////////////////////////
  // board pull-ups on the open-drain lines
  assign lrst_pin = lrst_oe ? lrst_o : 1'b1;
  assign int_pin = int_oe ? int_o : 1'b1;
  // event pin: device, else board driver, else pad pull-down
  assign mce_pin = mce_oe ? mce_o : (ev_drive ? held : 1'b0);

  ////////////////////////////////////////////////////////////////////
  // board driver moves only after its level has stood long enough
  always_ff @(posedge clk_sys) begin
    if (ev_level != held && stable_cnt >= 4'(rep_pkg::MCE_HOLD_CYC)) begin
      held <= ev_level;
      stable_cnt <= 4'h0;
    end else if (stable_cnt != 4'hF) begin
      stable_cnt <= stable_cnt + 4'h1;
    end
  end
endmodule

`default_nettype wire

// ---- verification/rep_reset_event_pins_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module rep_reset_event_pins_test;
  logic clk_sys = 1'b0, srst = 1'b1, req = 1'b0, sel = 1'b0, done = 1'b0, clr = 1'b0;
  logic dir = 1'b0, irq = 1'b0, ev_drive = 1'b1, ev_level = 1'b0, run = 1'b0;
  logic [15:0] rx = 16'h0, en = 16'h0, tx;
  logic lo, loe, mo, moe, io, ioe, lpin, ipin, mpin, e_l = 1'b1, e_i = 1'b1, e_m = 1'b0;
  logic [18:0] prev, obs, e, exp_q[$];
  logic [31:0] seed = 32'h00013635, r;
  int bad_count = 0, compares = 0, cycles = 0;

  rep_reset_event_pins #(.NUM_PORTS(16)) dut (.clk_sys(clk_sys), .srst(srst),
    .link_rst_req(req), .self_rst_sel(sel), .self_rst_done(done), .rst_req_clear(clr),
    .link_reset_out_n_o(lo), .link_reset_out_n_oe(loe), .mce_dir_out(dir),
    .multicast_event_pin_i(mpin), .multicast_event_pin_o(mo), .multicast_event_pin_oe(moe),
    .mce_rx(rx), .mce_port_en(en), .mce_tx_req(tx), .irq_pending(irq),
    .int_out_n_o(io), .int_out_n_oe(ioe));
  rep_board_model board (.clk_sys(clk_sys), .ev_drive(ev_drive), .ev_level(ev_level),
    .lrst_o(lo), .lrst_oe(loe), .int_o(io), .int_oe(ioe), .mce_o(mo), .mce_oe(moe),
    .lrst_pin(lpin), .int_pin(ipin), .mce_pin(mpin));

  ////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic note(input logic [15:0] t);
    exp_q.push_back({e_l, e_i, e_m, t});
  endtask

  task automatic final_report();
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one link reset hold: wrong release first, then the right one
  task automatic lrst(input logic mode);
    sel = mode;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    e_l = 1'b0;
    note(16'h0);
    cyc(3);
    {done, clr} = mode ? 2'b01 : 2'b10;
    cyc(1);
    {done, clr} = 2'b00;
    cyc(3);
    {done, clr} = mode ? 2'b10 : 2'b01;
    cyc(1);
    {done, clr} = 2'b00;
    e_l = 1'b1;
    note(16'h0);
    cyc(3);
  endtask

  ////////////////////////////////////////////////////////////////////
  // watcher: every change at the pins takes the oldest note
  always @(negedge clk_sys) begin
    obs = {lpin, ipin, mo, tx};
    if (run && obs !== prev) begin
      compares++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~obs;
      if (e !== obs) begin
        bad_count++;
        $display("unexpected at %0t: got %h expected %h", $time, obs, e);
      end
    end
    prev = obs;
  end

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(12);
    srst = 1'b0;
    cyc(2);
    run = 1'b1;
    lrst(1'b0);
    lrst(1'b1);
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    e_l = 1'b0;
    note(16'h0);
    cyc(3);
    srst = 1'b1;
    e_l = 1'b1;
    note(16'h0);
    cyc(4);
    srst = 1'b0;
    cyc(6);
    for (int i = 0; i < 13; i++) begin
      r = xs();
      if (r[0] || i == 12 && ev_level) begin
        ev_level = ~ev_level;
        note(16'hFFFF);
        note(16'h0);
      end
      cyc(12);
    end
    for (int i = 0; i < 25; i++) begin
      r = xs();
      if (i == 24) r[0] = 1'b0;
      if (r[0] !== irq) begin
        irq = r[0];
        e_i = ~r[0];
        note(16'h0);
      end
      cyc(1);
    end
    ev_drive = 1'b0;
    dir = 1'b1;
    cyc(3);
    // device now owns the event pin
    compares++;
    if (moe !== 1'b1 || mpin !== mo) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, {moe, mpin}, {1'b1, mo});
    end
    for (int i = 0; i < 24; i++) begin
      r = xs();
      en = r[31:16];
      rx = r[3] ? r[15:0] : 16'h0;
      if ((rx & en) != 16'h0) begin
        e_m = ~e_m;
        note(16'h0);
      end
      cyc(1);
    end
    rx = 16'h0;
    cyc(8);
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, 19'h0, exp_q[0]);
    end
    final_report();
  end
endmodule

`default_nettype wire
